// ===== src/front_panel_gpio_port.sv
`timescale 1ns/100ps
module front_panel_gpio_port
    import gpio_port_pkg::*;
#(
    parameter int REG_COUNT = gpio_port_pkg::CUSTOM_REG_COUNT
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic clock_enable_i,
    // single-ended pins
    input wire logic [gpio_port_pkg::SE_COUNT-1:0] se_pin_i,
    output logic [gpio_port_pkg::SE_COUNT-1:0] se_pin_o,
    output logic [gpio_port_pkg::SE_COUNT-1:0] se_pin_oe_o,
    // differential receivers and drivers
    input wire logic diff_in_a_pos_i,
    input wire logic diff_in_b_pos_i,
    input wire logic diff_clk_in_a_pos_i,
    input wire logic diff_clk_in_b_pos_i,
    output logic diff_out_a_pos_o,
    output logic diff_out_b_pos_o,
    output logic diff_out_c_pos_o,
    output logic diff_out_d_pos_o,
    // host port commands
    input wire logic set_port_direction_cmd_i,
    input wire logic [gpio_port_pkg::SE_COUNT-1:0] port_direction_i,
    input wire logic write_port_levels_cmd_i,
    input wire logic [gpio_port_pkg::PORT_WORD_W-1:0] port_wdata_i,
    input wire logic read_port_levels_cmd_i,
    output logic [gpio_port_pkg::PORT_WORD_W-1:0] port_rdata_o,
    output logic port_rvalid_o,
    // host custom register commands
    input wire logic write_custom_reg_cmd_i,
    input wire logic read_custom_reg_cmd_i,
    input wire logic [gpio_port_pkg::CUSTOM_ADDR_W-1:0] custom_addr_i,
    input wire logic [gpio_port_pkg::CUSTOM_DATA_W-1:0] custom_wdata_i,
    output logic [gpio_port_pkg::CUSTOM_DATA_W-1:0] custom_rdata_o,
    output logic custom_rvalid_o,
    // real-time firmware side
    output logic [gpio_port_pkg::PORT_WORD_W-1:0] fw_port_levels_o,
    output logic [REG_COUNT*gpio_port_pkg::CUSTOM_DATA_W-1:0] fw_regs_o,
    input wire logic [REG_COUNT*gpio_port_pkg::CUSTOM_DATA_W-1:0] fw_status_i
);
    localparam int SYNC_W = SE_COUNT + DIFF_IN_COUNT;

    typedef struct packed {
        logic [SE_COUNT-1:0] se_dir;
        logic [SE_COUNT-1:0] se_out;
        logic [DIFF_OUT_COUNT-1:0] diff_out;
        logic [PORT_WORD_W-1:0] port_rdata;
        logic port_rvalid;
        logic [REG_COUNT-1:0][CUSTOM_DATA_W-1:0] regs;
        logic [CUSTOM_DATA_W-1:0] custom_rdata;
        logic custom_rvalid;
    } port_s;

    port_s state_reg;
    port_s state_next;
    logic [PORT_WORD_W-1:0] levels;
    logic [SE_COUNT-1:0] se_level;

    if (REG_COUNT < 1 || REG_COUNT > (1 << CUSTOM_ADDR_W)) begin : g_check
        $error("REG_COUNT must fit the custom register address");
    end

    pin_sync_if #(.WIDTH(SYNC_W)) sync_bus ();

    assign sync_bus.raw = {diff_clk_in_b_pos_i, diff_clk_in_a_pos_i,
                           diff_in_b_pos_i, diff_in_a_pos_i, se_pin_i};

    pin_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .clock_enable_i(clock_enable_i),
        .sync(sync_bus.filter)
    );

    // driven lines read back their driven level
    always_comb begin
        for (int i = 0; i < SE_COUNT; i++) begin
            se_level[i] = state_reg.se_dir[i] ? state_reg.se_out[i]
                                              : sync_bus.level[i];
        end
    end

    // full port word: single-ended, diff inputs, diff outputs
    assign levels = {state_reg.diff_out,
                     sync_bus.level[SYNC_W-1:SE_COUNT], se_level};

    always_comb begin
        state_next = state_reg;
        state_next.port_rvalid = 1'b0;
        state_next.custom_rvalid = 1'b0;
        if (set_port_direction_cmd_i) begin
            state_next.se_dir = port_direction_i;
        end
        if (write_port_levels_cmd_i) begin
            state_next.se_out = port_wdata_i[SE_LSB +: SE_COUNT];
            state_next.diff_out = port_wdata_i[DIFF_OUT_LSB +: DIFF_OUT_COUNT];
        end
        if (read_port_levels_cmd_i) begin
            state_next.port_rdata = levels;
            state_next.port_rvalid = 1'b1;
        end
        if (write_custom_reg_cmd_i && custom_addr_i < REG_COUNT) begin
            state_next.regs[custom_addr_i] = custom_wdata_i;
        end
        if (read_custom_reg_cmd_i) begin
            state_next.custom_rdata = '0;
            for (int k = 0; k < REG_COUNT; k++) begin
                if (custom_addr_i == k[CUSTOM_ADDR_W-1:0]) begin
                    state_next.custom_rdata =
                        fw_status_i[k*CUSTOM_DATA_W +: CUSTOM_DATA_W];
                end
            end
            state_next.custom_rvalid = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            // lines start as inputs, values cleared
            state_reg.se_dir <= SE_DIR_RESET;
            state_reg.se_out <= SE_OUT_RESET;
            state_reg.diff_out <= DIFF_OUT_RESET;
            state_reg.port_rdata <= '0;
            state_reg.port_rvalid <= 1'b0;
            state_reg.regs <= {REG_COUNT{CUSTOM_REG_RESET}};
            state_reg.custom_rdata <= '0;
            state_reg.custom_rvalid <= 1'b0;
        end else if (clock_enable_i) begin
            state_reg <= state_next;
        end
    end

    // drive only lines set to output
    assign se_pin_oe_o = state_reg.se_dir;
    assign se_pin_o = state_reg.se_out;

    assign diff_out_a_pos_o = state_reg.diff_out[0];
    assign diff_out_b_pos_o = state_reg.diff_out[1];
    assign diff_out_c_pos_o = state_reg.diff_out[2];
    assign diff_out_d_pos_o = state_reg.diff_out[3];

    assign port_rdata_o = state_reg.port_rdata;
    assign port_rvalid_o = state_reg.port_rvalid;
    assign custom_rdata_o = state_reg.custom_rdata;
    assign custom_rvalid_o = state_reg.custom_rvalid;

    // firmware sees the live port and host-written registers
    assign fw_port_levels_o = levels;
    assign fw_regs_o = state_reg.regs;
endmodule

// ===== src/gpio_port_pkg.sv
package gpio_port_pkg;
    localparam int SE_COUNT = 12;
    localparam int DIFF_IN_COUNT = 4;
    localparam int DIFF_OUT_COUNT = 4;
    localparam int PORT_WORD_W = 20;
    localparam int CUSTOM_DATA_W = 32;
    localparam int CUSTOM_ADDR_W = 4;
    localparam int CUSTOM_REG_COUNT = 4;

    // field positions in the port level word
    localparam int SE_LSB = 0;
    localparam int DIFF_IN_LSB = 12;
    localparam int DIFF_OUT_LSB = 16;

    // values after reset
    localparam logic [SE_COUNT-1:0] SE_DIR_RESET = 12'h000;
    localparam logic [SE_COUNT-1:0] SE_OUT_RESET = 12'h000;
    localparam logic [DIFF_OUT_COUNT-1:0] DIFF_OUT_RESET = 4'h0;
    localparam logic [CUSTOM_DATA_W-1:0] CUSTOM_REG_RESET = 32'h00000000;
endpackage

// ===== src/pin_sync_if.sv
`timescale 1ns/100ps
interface pin_sync_if #(parameter int WIDTH = 1);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] level;
    modport source (output raw, input level);
    modport filter (input raw, output level);
endinterface

// ===== src/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic clock_enable_i,
    pin_sync_if.filter sync
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
        logic [WIDTH-1:0] stage3;
        logic [WIDTH-1:0] level;
    } sync_s;

    sync_s state_reg;
    sync_s state_next;

    if (WIDTH < 1) begin : g_check
        $error("pin_sync needs WIDTH of at least one");
    end

    always_comb begin
        state_next = state_reg;
        state_next.stage1 = sync.raw;
        state_next.stage2 = state_reg.stage1;
        state_next.stage3 = state_reg.stage2;
        for (int i = 0; i < WIDTH; i++) begin
            // change accepted once last two stages agree
            if (state_reg.stage2[i] == state_reg.stage3[i]) begin
                state_next.level[i] = state_reg.stage3[i];
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_reg <= '0;
        end else if (clock_enable_i) begin
            state_reg <= state_next;
        end
    end

    assign sync.level = state_reg.level;
endmodule

// ===== sim/front_panel_gpio_port_props.sv
`timescale 1ns/100ps
module front_panel_gpio_port_props (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic clock_enable_i,
    input wire logic [11:0] se_pin_o,
    input wire logic [11:0] se_pin_oe_o,
    input wire logic set_port_direction_cmd_i,
    input wire logic [11:0] port_direction_i,
    input wire logic write_port_levels_cmd_i,
    input wire logic [19:0] port_wdata_i,
    input wire logic read_port_levels_cmd_i,
    input wire logic [19:0] port_rdata_o,
    input wire logic port_rvalid_o,
    input wire logic diff_out_a_pos_o,
    input wire logic diff_out_b_pos_o,
    input wire logic diff_out_c_pos_o,
    input wire logic diff_out_d_pos_o,
    input wire logic [19:0] fw_port_levels_o
);
    logic wr, rd;
    logic [3:0] dv;
    assign wr = write_port_levels_cmd_i & clock_enable_i;
    assign rd = read_port_levels_cmd_i & clock_enable_i;
    assign dv = {diff_out_d_pos_o, diff_out_c_pos_o, diff_out_b_pos_o,
        diff_out_a_pos_o};
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    dir_load_a: assert property (
        set_port_direction_cmd_i & clock_enable_i |=>
        se_pin_oe_o == $past(port_direction_i)) else $error("bad direction");
    out_load_a: assert property (
        wr |=> se_pin_o == $past(port_wdata_i[11:0])) else $error("bad level");
    out_hold_a: assert property (
        !wr |=> $stable(se_pin_o)) else $error("level changed");
    diff_load_a: assert property (
        wr |=> dv == $past(port_wdata_i[19:16])) else $error("bad diff out");
    reset_state_a: assert property (
        $fell(reset_i) |-> se_pin_oe_o == 12'h000 && se_pin_o == 12'h000 &&
        dv == 4'h0) else $error("bad reset state");
    answer_once_a: assert property (
        port_rvalid_o && clock_enable_i && !rd |=> !port_rvalid_o)
        else $error("answer too long");
    read_answer_a: assert property (
        rd |=> port_rvalid_o && port_rdata_o[19:16] == $past(dv) &&
        ((port_rdata_o[11:0] ^ $past(se_pin_o)) & $past(se_pin_oe_o)) ==
        12'h000) else $error("bad read answer");
    fw_word_a: assert property (
        fw_port_levels_o[19:16] == dv &&
        ((fw_port_levels_o[11:0] ^ se_pin_o) & se_pin_oe_o) == 12'h000)
        else $error("firmware word differs");
endmodule
bind front_panel_gpio_port front_panel_gpio_port_props props (.*);

// ===== sim/panel_equipment.sv
`timescale 1ns/100ps
module panel_equipment (
    input wire logic [11:0] drive_i,
    input wire logic [11:0] enable_i,
    input wire logic [11:0] far_level_i,
    output wire logic [11:0] line_o
);
    // device level where it drives, equipment level elsewhere
    assign line_o = (drive_i & enable_i) | (far_level_i & ~enable_i);
endmodule

// ===== sim/front_panel_gpio_port_tb.sv
`timescale 1ns/100ps
module front_panel_gpio_port_tb;
    import gpio_port_pkg::*;
    typedef struct {logic [11:0] d; logic [19:0] w, x, r;} row_s;
    logic clock_i = 0, reset_i = 1, ce = 1, sd = 0, wr = 0, rd = 0;
    logic cw = 0, cr = 0, rv, crv;
    logic [11:0] dir = 0, so, soe;
    logic [15:0] ext = 0;
    wire [11:0] line;
    logic [3:0] dout, ca = 0;
    logic [19:0] wd = 0, rdat, fwl;
    logic [31:0] cwd = 0, crd;
    logic [127:0] fws = 0, fwr;
    int num_errors = 0, num_checks = 0;
    row_s rows[4] = '{'{12'h000, 20'h00000, 20'h05A5C, 20'h05A5C},
        '{12'hFFF, 20'hAF123, 20'hAA123, 20'hAA123},
        '{12'h0F0, 20'h50F0F, 20'h53F0F, 20'h53F0F},
        '{12'h801, 20'h3FFFF, 20'h3C7FF, 20'h3CFFF}};
    front_panel_gpio_port dut (.clock_i, .reset_i, .clock_enable_i(ce),
        .se_pin_i(line), .se_pin_o(so), .se_pin_oe_o(soe),
        .diff_in_a_pos_i(ext[12]), .diff_in_b_pos_i(ext[13]),
        .diff_clk_in_a_pos_i(ext[14]), .diff_clk_in_b_pos_i(ext[15]),
        .diff_out_a_pos_o(dout[0]), .diff_out_b_pos_o(dout[1]),
        .diff_out_c_pos_o(dout[2]), .diff_out_d_pos_o(dout[3]),
        .set_port_direction_cmd_i(sd), .port_direction_i(dir),
        .write_port_levels_cmd_i(wr), .port_wdata_i(wd),
        .read_port_levels_cmd_i(rd), .port_rdata_o(rdat), .port_rvalid_o(rv),
        .write_custom_reg_cmd_i(cw), .read_custom_reg_cmd_i(cr),
        .custom_addr_i(ca), .custom_wdata_i(cwd), .custom_rdata_o(crd),
        .custom_rvalid_o(crv), .fw_port_levels_o(fwl), .fw_regs_o(fwr),
        .fw_status_i(fws));
    panel_equipment far (.drive_i(so), .enable_i(soe),
        .far_level_i(ext[11:0]),
        .line_o(line));
    always #25 clock_i = ~clock_i;
    task cyc;
        @(posedge clock_i);
        #5;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            num_errors++;
            $display("wrong value at %0t: %h vs %h", $time, got, want);
        end
    endtask
    task close_out;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        num_errors++;
        close_out;
    end
    initial begin
        repeat (8) cyc;
        reset_i = 0;
        chk({soe, so, dout}, 32'h0);
        foreach (rows[k]) begin
            {dir, wd, ext} = {rows[k].d, rows[k].w, rows[k].x[15:0]};
            {sd, wr} = 2'h3;
            cyc;
            {sd, wr} = 2'h0;
            chk({soe, so & dir, dout}, {dir, wd[11:0] & dir, wd[19:16]});
            repeat (6) cyc;
            rd = 1;
            cyc;
            rd = 0;
            chk({rv, rdat}, {1'h1, rows[k].r});
            chk(fwl, rows[k].r);
            $display("row %0d done", k);
        end
        {ce, wr, wd} = {2'h1, 20'h12345};
        cyc;
        {ce, wr, rd, wd} = {3'h7, 20'h00000};
        cyc;
        {wr, rd} = 2'h0;
        chk({rdat[19:16], dout}, 32'h30);
        $display("enable test done");
        fws = {32'hDDDD0004, 32'hCCCC0003, 32'hBBBB0002, 32'hAAAA0001};
        {cw, ca, cwd} = {5'h12, 32'h1234ABCD};
        cyc;
        {cw, cr, ca} = 6'h11;
        cyc;
        chk({crv, crd}, {1'h1, 32'hBBBB0002});
        {cw, cr, ca, cwd} = {6'h35, 32'hFFFFFFFF};
        cyc;
        {cw, cr} = 2'h0;
        chk({crv, crd}, {1'h1, 32'h0});
        chk(fwr[95:64] ^ fwr[31:0], 32'h1234ABCD);
        $display("custom test done");
        reset_i = 1;
        cyc;
        reset_i = 0;
        chk({soe, so, dout, fwr[95:92]}, 32'h0);
        chk(fwr[127:96] | fwr[95:64] | fwr[63:32] | fwr[31:0], 32'h0);
        $display("reset test done");
        close_out;
    end
endmodule
